/* rat_alias_remap.v */
// remote target address translation: two port copies of target and alias
// registers, register access port, and the alias-to-target address remap.
// assumes the I2C target engine hands each local address here as a pulse
// and forwards the result over the control channel.
//
// Contract
// [R1] target registers hold a 7-bit address in bits 7:1; bit 0 reserved.
// [R2] a local address matching slot n's alias is replaced by slot n's target.
// [R3] a zero target field disables remapping through that slot.
// [R4] with port select set, target register accesses reach the port 1 copy.
// [R5] alias register 1 holds a 7-bit alias in bits 7:1; bit 0 reserved.
// [R6] a match on alias slot 1 is remapped to target slot 1.
// [R7] a zero alias field never matches any local address.
// [R8] with port select set, alias register accesses reach the port 1 copy.
// [R9] compare upper seven bits with every nonzero alias; first match wins.
`timescale 1ns/100ps
`default_nettype none
`include "rat_regs.vh"

module rat_alias_remap #(
    parameter NPORT   = 2,
    parameter ENTRIES = `RAT_BANK_ENTRIES,
    parameter IDX_W   = `RAT_BANK_IDX_W,
    parameter FIELD_W = `RAT_FIELD_W
) (
    // clock and reset
    input  wire                      clk,
    input  wire                      rst_b,
    // register access
    input  wire                      second_port_select,
    input  wire                      reg_wr,
    input  wire                      reg_rd,
    input  wire [`RAT_ADDR_W-1:0]    reg_addr,
    input  wire [`RAT_DATA_W-1:0]    reg_wdata,
    output reg  [`RAT_DATA_W-1:0]    reg_rdata_q,
    output reg                       reg_rvalid_q,
    // local transaction address in
    input  wire                      xlate_req,
    input  wire                      xlate_port,
    input  wire [`RAT_DATA_W-1:0]    xlate_addr,
    // forwarded address out
    output reg                       fwd_valid_q,
    output reg                       fwd_miss_q,
    output reg                       fwd_port_q,
    output reg  [IDX_W-1:0]          fwd_slot_q,
    output reg  [`RAT_DATA_W-1:0]    fwd_addr_q
);

    // reset release through two flops
    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // address decode: offsets 0x70..0x77 form one bank window
    wire             in_window;
    wire [IDX_W-1:0] acc_idx;
    wire             acc_impl;
    // one bit per offset in the window; the hole at 0x71 is cleared
    wire [`RAT_BANK_ENTRIES-1:0] impl_mask;
    assign in_window = (reg_addr[`RAT_ADDR_W-1:IDX_W] == `RAT_BANK_BASE_HI);
    assign acc_idx   = reg_addr[IDX_W-1:0];
    assign impl_mask = `RAT_BANK_IMPL;
    assign acc_impl  = in_window && impl_mask[acc_idx];

    // bit 0 is dropped on write; only the 7-bit field is stored
    wire [FIELD_W-1:0] wr_field;
    assign wr_field = reg_wdata[`RAT_FIELD_MSB:`RAT_FIELD_LSB]; // [R1] [R5]

    wire [NPORT*ENTRIES*FIELD_W-1:0] bank_entries;
    wire [NPORT*FIELD_W-1:0]         bank_rd;

    genvar p;
    generate
        for (p = 0; p < NPORT; p = p + 1) begin : g_port
            wire port_hit;
            // one select steers target and alias accesses alike
            assign port_hit = (second_port_select == p); // [R4] [R8]
            rat_port_bank #(
                .ENTRIES (ENTRIES),
                .IDX_W   (IDX_W),
                .FIELD_W (FIELD_W),
                .IMPL    (`RAT_BANK_IMPL)
            ) u_bank (
                .clk        (clk),
                .rst_n      (rst_n_q),
                .wr_en      (reg_wr && acc_impl && port_hit),
                .wr_idx     (acc_idx),
                .wr_field   (wr_field),
                .rd_idx     (acc_idx),
                .rd_field_q (bank_rd[p*FIELD_W +: FIELD_W]),
                .entries    (bank_entries[p*ENTRIES*FIELD_W +:
                                          ENTRIES*FIELD_W])
            );
        end
    endgenerate

    // read path: bank read data is one cycle late, so hold the access
    // attributes for the same cycle and pick the copy then
    reg rd_pend_q;
    reg rd_impl_q;
    reg rd_port_q;
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_pend_q <= 1'b0;
            rd_impl_q <= 1'b0;
            rd_port_q <= 1'b0;
        end else begin
            rd_pend_q <= reg_rd;
            rd_impl_q <= acc_impl;
            rd_port_q <= second_port_select; // [R4] [R8]
        end
    end

    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= rd_pend_q;
            if (rd_pend_q && rd_impl_q) begin
                // reserved bit 0 reads as zero
                reg_rdata_q <= {bank_rd[rd_port_q*FIELD_W +: FIELD_W],
                                1'b0}; // [R1] [R5]
            end else if (rd_pend_q) begin
                // unmapped or absent slot reads as zero
                reg_rdata_q <= 8'h00;
            end
        end
    end

    // translation: pick the table of the port the transaction goes to
    wire [ENTRIES*FIELD_W-1:0] tbl;
    assign tbl = bank_entries[xlate_port*ENTRIES*FIELD_W +: ENTRIES*FIELD_W];

    wire [FIELD_W-1:0] local_addr;
    assign local_addr = xlate_addr[`RAT_FIELD_MSB:`RAT_FIELD_LSB]; // [R9]

    // alias entries, by slot; slots without an alias register stay zero
    // in this bank and therefore never match
    wire [FIELD_W-1:0] alias_of [0:ENTRIES-1];
    wire [FIELD_W-1:0] target_of [0:ENTRIES-1];
    wire [ENTRIES-1:0] slot_hit;

    genvar s;
    generate
        for (s = 0; s < ENTRIES; s = s + 1) begin : g_slot
            if (s == 1) begin : g_a1
                assign alias_of[s]  = tbl[`RAT_IDX_ALIAS_1*FIELD_W +:
                                          FIELD_W];
                assign target_of[s] = tbl[`RAT_IDX_TARGET_1*FIELD_W +:
                                          FIELD_W]; // [R6]
            end else begin : g_na
                assign alias_of[s]  = {FIELD_W{1'b0}};
                assign target_of[s] = {FIELD_W{1'b0}};
            end
            // zero alias never matches; zero target disables the slot
            assign slot_hit[s] = (alias_of[s] != {FIELD_W{1'b0}}) && // [R7]
                                 (alias_of[s] == local_addr) &&      // [R9]
                                 (target_of[s] != {FIELD_W{1'b0}});  // [R3]
        end
    endgenerate

    // first match in ascending slot order
    reg             any_hit;
    reg [IDX_W-1:0] hit_slot;
    integer         i;
    always @* begin
        any_hit  = 1'b0;
        hit_slot = {IDX_W{1'b0}};
        for (i = 0; i < ENTRIES; i = i + 1) begin
            if (slot_hit[i] && !any_hit) begin // [R9]
                any_hit  = 1'b1;
                hit_slot = i[IDX_W-1:0];
            end
        end
    end

    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fwd_valid_q <= 1'b0;
            fwd_miss_q  <= 1'b0;
            fwd_port_q  <= 1'b0;
            fwd_slot_q  <= {IDX_W{1'b0}};
            fwd_addr_q  <= 8'h00;
        end else begin
            fwd_valid_q <= xlate_req && any_hit;
            fwd_miss_q  <= xlate_req && !any_hit;
            if (xlate_req) begin
                fwd_port_q <= xlate_port;
                fwd_slot_q <= hit_slot;
                // real address replaces the alias; r/w bit passes through
                fwd_addr_q <= any_hit ?
                    {target_of[hit_slot], xlate_addr[0]} : 8'h00; // [R2]
            end
        end
    end

endmodule

`default_nettype wire

/* rat_regs.vh */
// register offsets, field layout and reset values for the alias remap block
// assumes byte-wide register accesses with 8-bit offsets
`ifndef RAT_REGS_VH
`define RAT_REGS_VH

`define RAT_ADDR_W            8
`define RAT_DATA_W            8
`define RAT_FIELD_W           7
`define RAT_FIELD_MSB         7
`define RAT_FIELD_LSB         1

`define RAT_OFS_TARGET_1      8'h70
`define RAT_OFS_TARGET_3      8'h72
`define RAT_OFS_TARGET_4      8'h73
`define RAT_OFS_TARGET_5      8'h74
`define RAT_OFS_TARGET_6      8'h75
`define RAT_OFS_TARGET_7      8'h76
`define RAT_OFS_ALIAS_1       8'h77

`define RAT_BANK_BASE_HI      5'h0E
`define RAT_BANK_ENTRIES      8
`define RAT_BANK_IDX_W        3
`define RAT_BANK_IMPL         8'hFD
`define RAT_IDX_ALIAS_1       3'h7
`define RAT_IDX_TARGET_1      3'h0

`define RAT_RESET_VAL         7'h00
`define RAT_READ_LATENCY      1

`endif

/* rat_port_bank.v */
// one port's copy of the target-address and alias registers
// assumes writes arrive already decoded to an entry index
`timescale 1ns/100ps
`default_nettype none
`include "rat_regs.vh"

module rat_port_bank #(
    parameter ENTRIES = `RAT_BANK_ENTRIES,
    parameter IDX_W   = `RAT_BANK_IDX_W,
    parameter FIELD_W = `RAT_FIELD_W,
    parameter [`RAT_BANK_ENTRIES-1:0] IMPL = `RAT_BANK_IMPL
) (
    // clock and reset
    input  wire                       clk,
    input  wire                       rst_n,
    // write side
    input  wire                       wr_en,
    input  wire [IDX_W-1:0]           wr_idx,
    input  wire [FIELD_W-1:0]         wr_field,
    // read side
    input  wire [IDX_W-1:0]           rd_idx,
    output reg  [FIELD_W-1:0]         rd_field_q,
    // all entries, flat
    output wire [ENTRIES*FIELD_W-1:0] entries
);

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
            if (IMPL[g]) begin : g_impl
                reg [FIELD_W-1:0] field_q;
                always @(posedge clk or negedge rst_n) begin
                    if (!rst_n) begin
                        field_q <= `RAT_RESET_VAL;
                    end else if (wr_en && wr_idx == g) begin
                        field_q <= wr_field;
                    end
                end
                assign entries[g*FIELD_W +: FIELD_W] = field_q;
            end else begin : g_hole
                // slot outside this bank reads as zero, so it never matches
                assign entries[g*FIELD_W +: FIELD_W] = {FIELD_W{1'b0}};
            end
        end
    endgenerate

    // read data comes out of a register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_field_q <= `RAT_RESET_VAL;
        end else begin
            rd_field_q <= entries[rd_idx*FIELD_W +: FIELD_W];
        end
    end

endmodule

`default_nettype wire

/* rat_alias_remap_assertions.sv */
// checker for the alias remap block ports
// assumes bind onto rat_alias_remap, single clock domain
`timescale 1ns/100ps
`default_nettype none
module rat_alias_remap_chk (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // register access
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic       reg_rvalid_q,
    // translation
    input wire logic       xlate_req,
    input wire logic [7:0] xlate_addr,
    input wire logic       fwd_valid_q,
    input wire logic       fwd_miss_q,
    input wire logic [2:0] fwd_slot_q,
    input wire logic [7:0] fwd_addr_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_rd_lat; reg_rd |-> ##2 reg_rvalid_q; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read late");
    property p_rv; reg_rvalid_q |-> $past(reg_rd, 2); endproperty
    a_rv: assert property (p_rv) else $error("stray read answer");
    property p_b0; reg_rvalid_q |-> !reg_rdata_q[0]; endproperty
    a_b0: assert property (p_b0) else $error("bit 0 set");
    property p_ans; xlate_req |=> fwd_valid_q != fwd_miss_q; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_rw; fwd_valid_q |-> fwd_addr_q[0] == $past(xlate_addr[0]);
    endproperty
    a_rw: assert property (p_rw) else $error("rw bit lost");
    property p_miss; fwd_miss_q |-> fwd_addr_q == 8'h00 && fwd_slot_q == 3'h0;
    endproperty
    a_miss: assert property (p_miss) else $error("miss not clear");
    property p_hit; fwd_valid_q |-> fwd_slot_q == 3'h1 && |fwd_addr_q[7:1];
    endproperty
    a_hit: assert property (p_hit) else $error("bad hit");
    property p_z; xlate_req && xlate_addr[7:1] == 7'h00 |=> fwd_miss_q;
    endproperty
    a_z: assert property (p_z) else $error("zero matched");
endmodule
bind rat_alias_remap rat_alias_remap_chk chk_u (.clk(clk), .rst_b(rst_b),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .xlate_req(xlate_req), .xlate_addr(xlate_addr),
    .fwd_valid_q(fwd_valid_q), .fwd_miss_q(fwd_miss_q),
    .fwd_slot_q(fwd_slot_q), .fwd_addr_q(fwd_addr_q));
`default_nettype wire

/* rat_host_model.sv */
// local host model: one translation request at a time
// assumes callers run in step with clk
`timescale 1ns/100ps
`default_nettype none
module rat_host_model (
    // clock
    input  wire logic       clk,
    // request to the remap block
    output var  logic       xlate_req,
    output var  logic       xlate_port,
    output var  logic [7:0] xlate_addr
);
    initial begin
        xlate_req = 1'b0;
        xlate_port = 1'b0;
        xlate_addr = 8'h00;
    end
    task automatic send(input logic p, input logic [7:0] a);
        @(posedge clk);
        #1;
        xlate_req = 1'b1;
        xlate_port = p;
        xlate_addr = a;
        @(posedge clk);
        #1;
        xlate_req = 1'b0;
        // released byte shows its inverse, never the stale value
        xlate_addr = ~a;
    endtask
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the alias remap block
// assumes rat_alias_remap and rat_host_model are compiled alongside
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst_b = 1'b0, second_port_select = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    wire logic [7:0] reg_rdata_q, xlate_addr, fwd_addr_q;
    wire logic [2:0] fwd_slot_q;
    wire logic reg_rvalid_q, xlate_req, xlate_port, fwd_valid_q, fwd_miss_q;
    wire logic fwd_port_q;
    int err_total = 0, comparisons = 0, cyc = 0;
    rat_host_model host_u (.clk(clk), .xlate_req(xlate_req),
        .xlate_port(xlate_port), .xlate_addr(xlate_addr));
    rat_alias_remap dut_u (.clk(clk), .rst_b(rst_b),
        .second_port_select(second_port_select), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .xlate_req(xlate_req), .xlate_port(xlate_port),
        .xlate_addr(xlate_addr), .fwd_valid_q(fwd_valid_q),
        .fwd_miss_q(fwd_miss_q), .fwd_port_q(fwd_port_q),
        .fwd_slot_q(fwd_slot_q), .fwd_addr_q(fwd_addr_q));
    always #5 clk = ~clk;
    task automatic close_out;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard, well above the roughly two hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            close_out;
        end
    end
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        second_port_select = p;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic p, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1;
        second_port_select = p;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        // answer is launched one edge after the taking edge
        @(posedge clk);
        #1 chk("rvalid", 8'h01, {7'h00, reg_rvalid_q});
        chk("rdata", e, reg_rdata_q);
        @(posedge clk);
        #1 chk("rvalid_end", 8'h00, {7'h00, reg_rvalid_q});
        chk("rdata_hold", e, reg_rdata_q);
    endtask
    task automatic xl(input logic p, input logic [7:0] a, input logic h,
                      input logic [7:0] e);
        // send returns just after the edge that launches the answer
        host_u.send(p, a);
        chk("hit", {7'h00, h}, {7'h00, fwd_valid_q});
        chk("miss", {7'h00, !h}, {7'h00, fwd_miss_q});
        chk("fwd_addr", e, fwd_addr_q);
        chk("slot", {7'h00, h}, {5'h00, fwd_slot_q});
        chk("port", {7'h00, p}, {7'h00, fwd_port_q});
        @(posedge clk);
        #1 chk("pulse_end", 8'h00, {6'h00, fwd_valid_q, fwd_miss_q});
        chk("fwd_hold", e, fwd_addr_q);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 16; i++)
            rd(i[3], 8'h70 + i[2:0], 8'h00);
    endtask
    task automatic t_regs;
        for (int i = 1; i < 8; i++) begin
            wr(1'b0, 8'h70 + i[2:0], 8'hFF);
            rd(1'b0, 8'h70 + i[2:0], i == 1 ? 8'h00 : 8'hFE);
            rd(1'b1, 8'h70 + i[2:0], 8'h00);
        end
    endtask
    task automatic t_remap;
        wr(1'b0, 8'h70, 8'h54);
        wr(1'b0, 8'h77, 8'h40);
        xl(1'b0, 8'h41, 1'b1, 8'h55);
        xl(1'b0, 8'h40, 1'b1, 8'h54);
        xl(1'b1, 8'h41, 1'b0, 8'h00);
        xl(1'b0, 8'h43, 1'b0, 8'h00);
        wr(1'b1, 8'h77, 8'h40);
        xl(1'b1, 8'h41, 1'b0, 8'h00);
        wr(1'b1, 8'h70, 8'h30);
        xl(1'b1, 8'h40, 1'b1, 8'h30);
    endtask
    task automatic t_zero;
        wr(1'b0, 8'h77, 8'h00);
        xl(1'b0, 8'h00, 1'b0, 8'h00);
        xl(1'b0, 8'h41, 1'b0, 8'h00);
        wr(1'b0, 8'h77, 8'h40);
        wr(1'b0, 8'h70, 8'h00);
        xl(1'b0, 8'h41, 1'b0, 8'h00);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_regs;
        t_remap;
        t_zero;
        close_out;
    end
endmodule
`default_nettype wire
